// ===== sdram_pin_command_interface.sv
// Purpose: synchronous command and data pin side of a four-bank sdram.
// Assumes: pins arrive synchronous to clk_in; dq split into in, out, enable.
// Notes: array keeps only ROW_KEEP row and COL_KEEP column bits per bank.
module sdram_pin_command_interface #(
  parameter int DQ_W     = 16,
  parameter int ROW_KEEP = 2,
  parameter int COL_KEEP = 4
) (
  input  wire logic                                clk_in,
  input  wire logic                                reset_n_in,
  input  wire logic                                clock_gate_in,
  input  wire logic                                chip_select_n_in,
  input  wire logic                                row_strobe_n_in,
  input  wire logic                                column_strobe_n_in,
  input  wire logic                                write_strobe_n_in,
  input  wire logic [sdram_pins_pkg::BANK_W-1:0]   bank_select_in,
  input  wire logic [sdram_pins_pkg::ADDR_W-1:0]   address_in,
  input  wire logic                                low_byte_mask_in,
  input  wire logic                                high_byte_mask_in,
  input  wire logic [DQ_W-1:0]                     dq_in,
  output logic [DQ_W-1:0]                          dq_out,
  output logic [DQ_W-1:0]                          dq_oe_out,
  output sdram_pins_pkg::power_mode_t              power_mode_out,
  output logic [sdram_pins_pkg::BANKS-1:0]         bank_open_out,
  output logic                                     input_buffers_on_out,
  output logic                                     burst_active_out
);
  import sdram_pins_pkg::*;
  localparam int IDX_W = BANK_W + ROW_KEEP + COL_KEEP;
  localparam int DEPTH = 1 << IDX_W;
  localparam logic [COL_KEEP:0] PAGE_LEN = (COL_KEEP+1)'(1 << COL_KEEP);

  typedef struct packed {
    logic                           cke;
    logic                           cs_n;
    logic [2:0]                     cmd;
    logic [BANK_W-1:0]              ba;
    logic [ADDR_W-1:0]              addr;
    logic [DQ_W-1:0]                dq;
    logic [1:0]                     mask;
    logic [1:0]                     mask_d1;
    logic [1:0]                     mask_d2;
    power_mode_t                    pmode;
    logic [BANKS-1:0]               open;
    logic [BANKS-1:0][ADDR_W-1:0]   rows;
    logic [ADDR_W-1:0]              mode;
    logic                           burst_on;
    logic                           burst_wr;
    logic                           burst_ap;
    logic [BANK_W-1:0]              burst_ba;
    logic [COL_KEEP-1:0]            base;
    logic [COL_KEEP:0]              cnt;
    logic [DEPTH-1:0][DQ_W-1:0]     mem;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic                run;
  logic                inbuf_on;
  logic                cmd_ok;
  logic                cmd_start;
  logic                wr_now;
  logic                ap_now;
  logic [BANK_W-1:0]   bank_now;
  logic [COL_KEEP:0]   cnt_now;
  logic [COL_KEEP-1:0] col_now;
  logic [ADDR_W-1:0]   row_now;
  logic [IDX_W-1:0]    idx_now;
  logic                go;
  logic                beat;
  logic                last;
  logic [DQ_W-1:0]     wr_lanes;
  logic                buf_in_ready;
  logic                buf_out_valid;
  logic                buf_out_ready;
  logic [DQ_W-1:0]     buf_out_data;

  // lane ownership of the two masks
  function automatic logic [DQ_W-1:0] lane_mask(input logic [1:0] m);
    for (int i = 0; i < DQ_W; i++) begin
      lane_mask[i] = (DQ_W == 16 && i < 8) ? m[0] : m[1];
    end
  endfunction

  function automatic logic [COL_KEEP-1:0] col_of(input logic [ADDR_W-1:0] a);
    logic [10:0] c;
    if (DQ_W == 4) begin
      c = {a[X4_COL_HI], a[X8_COL_TOP:0]};
    end else if (DQ_W == 8) begin
      c = {1'b0, a[X8_COL_TOP:0]};
    end else begin
      c = {2'b0, a[X16_COL_TOP:0]};
    end
    col_of = c[COL_KEEP-1:0];
  endfunction

  function automatic logic [COL_KEEP:0] burst_len(input logic [BL_W-1:0] code);
    case (code)
      3'h0: burst_len = (COL_KEEP+1)'(1);
      3'h1: burst_len = (COL_KEEP+1)'(2);
      3'h2: burst_len = (COL_KEEP+1)'(4);
      3'h3: burst_len = (COL_KEEP+1)'(8);
      default: burst_len = PAGE_LEN;
    endcase
  endfunction

  // pins other than the clock gate only listen while awake
  assign run      = state_reg.pmode == PM_RUN;
  assign inbuf_on = run || state_reg.pmode == PM_SUSPEND;
  // chip select gates the decoder, gate low stops commands
  assign cmd_ok    = run && state_reg.cke && !state_reg.cs_n;
  // decode from the registered strobe pattern
  assign cmd_start = cmd_ok && (state_reg.cmd == CMD_RD || state_reg.cmd == CMD_WR);
  assign wr_now    = cmd_start ? state_reg.cmd == CMD_WR : state_reg.burst_wr;
  // auto precharge flag taken with the column
  assign ap_now    = cmd_start ? state_reg.addr[AP_BIT] : state_reg.burst_ap;
  assign bank_now  = cmd_start ? state_reg.ba : state_reg.burst_ba;
  assign cnt_now   = cmd_start ? '0 : state_reg.cnt;
  assign col_now   = (cmd_start ? col_of(state_reg.addr) : state_reg.base)
                     + cnt_now[COL_KEEP-1:0];
  // row comes from the earlier activate
  assign row_now   = state_reg.rows[bank_now];
  assign idx_now   = {bank_now, row_now[ROW_KEEP-1:0], col_now};
  // bursts run on regardless of chip select
  assign go        = cmd_start || (state_reg.burst_on && run && state_reg.cke);
  // read beats wait when the output buffer is full
  assign beat      = go && (wr_now || buf_in_ready);
  assign last      = state_reg.mode[BL_LSB +: BL_W] != BL_FULL
                     && cnt_now == burst_len(state_reg.mode[BL_LSB +: BL_W])
                        - (COL_KEEP+1)'(1);
  assign wr_lanes  = lane_mask(state_reg.mask);
  // output side freezes during clock suspend
  assign buf_out_ready = run && state_reg.cke;

  sdram_word_buffer #(
    .W     (DQ_W),
    .DEPTH (BUF_DEPTH)
  ) u_read_buffer (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (go && !wr_now),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (state_reg.mem[idx_now]),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (buf_out_ready),
    .out_data_out  (buf_out_data)
  );

  always_comb begin
    state_next = state_reg;
    state_next.cke = clock_gate_in;
    if (inbuf_on) begin
      state_next.cs_n = chip_select_n_in;
      state_next.cmd  = {row_strobe_n_in, column_strobe_n_in, write_strobe_n_in};
      state_next.ba   = bank_select_in;
      state_next.addr = address_in;
      state_next.dq   = dq_in;
      state_next.mask = {high_byte_mask_in, low_byte_mask_in};
    end
    // two-stage mask pipe toward the output enables
    state_next.mask_d1 = state_reg.mask;
    state_next.mask_d2 = state_reg.mask_d1;
    if (cmd_start) begin
      state_next.burst_on = 1'b1;
      state_next.burst_wr = wr_now;
      state_next.burst_ap = ap_now;
      state_next.burst_ba = bank_now;
      state_next.base     = col_of(state_reg.addr);
      state_next.cnt      = '0;
    end
    // burst counter steps on the clock
    if (beat) begin
      // masked lanes keep the stored bits
      if (wr_now) begin
        state_next.mem[idx_now] = (state_reg.mem[idx_now] & wr_lanes)
                                  | (state_reg.dq & ~wr_lanes);
      end
      state_next.cnt = cnt_now + (COL_KEEP+1)'(1);
      if (last) begin
        state_next.burst_on = 1'b0;
        if (ap_now) begin
          state_next.open[bank_now] = 1'b0;
        end
      end
    end
    if (cmd_ok) begin
      case (state_reg.cmd)
        CMD_ACT: begin
          state_next.open[state_reg.ba] = 1'b1;
          state_next.rows[state_reg.ba] = state_reg.addr;
        end
        CMD_BST: begin
          state_next.burst_on = 1'b0;
        end
        // all banks or the selected one
        CMD_PRE: begin
          if (state_reg.addr[AP_BIT]) begin
            state_next.open = '0;
          end else begin
            state_next.open[state_reg.ba] = 1'b0;
          end
        end
        CMD_MODE: begin
          state_next.mode = state_reg.addr;
        end
        default: begin
        end
      endcase
    end
    // what a low clock gate means depends on activity
    case (state_reg.pmode)
      PM_RUN: begin
        if (!state_reg.cke) begin
          if (state_reg.burst_on) begin
            state_next.pmode = PM_SUSPEND;
          end else if (|state_reg.open) begin
            state_next.pmode = PM_ACT_DOWN;
          end else if (!state_reg.cs_n && state_reg.cmd == CMD_REF) begin
            state_next.pmode = PM_SELF_REF;
          end else begin
            state_next.pmode = PM_PRE_DOWN;
          end
        end
      end
      PM_SUSPEND: begin
        if (state_reg.cke) begin
          state_next.pmode = PM_RUN;
        end
      end
      // raw gate pin wakes the part, no registered stage in between
      PM_PRE_DOWN, PM_ACT_DOWN, PM_SELF_REF: begin
        if (clock_gate_in) begin
          state_next.pmode = PM_RUN;
        end
      end
      default: begin
        state_next.pmode = PM_RUN;
      end
    endcase
  end

  // single rising-edge register for all pins and state
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      // clock active and deselected, so release never dips into power-down
      state_reg      <= '0;
      state_reg.cke  <= 1'b1;
      state_reg.cs_n <= 1'b1;
      state_reg.cmd  <= CMD_NOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // dq width set by DQ_W; masked lanes released
  assign dq_out               = buf_out_data;
  assign dq_oe_out            = {DQ_W{buf_out_valid}} & ~lane_mask(state_reg.mask_d2);
  assign power_mode_out       = state_reg.pmode;
  assign bank_open_out        = state_reg.open;
  assign input_buffers_on_out = inbuf_on;
  assign burst_active_out     = state_reg.burst_on;

  a_mask_hiz_lat: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state_reg.mask[1] |-> ##2 !dq_oe_out[DQ_W-1]) else $error("mask latency wrong");
  a_cs_masks_cmd: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state_reg.cs_n && !state_reg.burst_on) |=> $stable(bank_open_out))
    else $error("command taken with chip select high");
  a_act_opens_row: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cmd_ok && state_reg.cmd == CMD_ACT) |=> state_reg.open[$past(state_reg.ba)]
      && state_reg.rows[$past(state_reg.ba)] == $past(state_reg.addr))
    else $error("activate did not latch row");
  a_pre_all_banks: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cmd_ok && state_reg.cmd == CMD_PRE && state_reg.addr[AP_BIT]) |=> state_reg.open == '0)
    else $error("precharge all left a bank open");
  a_mode_load_op: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cmd_ok && state_reg.cmd == CMD_MODE) |=> state_reg.mode == $past(state_reg.addr))
    else $error("mode word not loaded");
  a_suspend_entry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (run && !state_reg.cke && state_reg.burst_on) |=> state_reg.pmode == PM_SUSPEND)
    else $error("burst did not suspend");
  a_idle_down: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (run && !state_reg.cke && !state_reg.burst_on && state_reg.open == '0)
      |=> state_reg.pmode inside {PM_PRE_DOWN, PM_SELF_REF})
    else $error("idle part did not power down");
  a_inbuf_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !inbuf_on |=> $stable(state_reg.addr) && $stable(state_reg.cmd))
    else $error("inputs captured while asleep");
  a_wake_async: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!inbuf_on && clock_gate_in) |=> state_reg.pmode == PM_RUN)
    else $error("gate high did not wake part");
  a_wr_mask_keep: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (beat && wr_now && wr_lanes == '1)
      |=> state_reg.mem[$past(idx_now)] == $past(state_reg.mem[idx_now]))
    else $error("masked write changed data");
endmodule

// ===== sdram_pins_pkg.sv
// Purpose: shared constants and types for the sdram pin command interface.
// Assumes: strobes are active low; command code is {row, column, write} strobes.
// Notes: memory array is a shrunken flip-flop model; widths are parameters.
// Function
// - every input is registered on the rising system clock edge only.
// - burst counter and output registers advance on the system clock.
// - clock gate high means clock active, low means clock deactivated.
// - gate low: idle gives power-down/self refresh, open row active-down, burst suspend.
// - in power-down or self refresh the clock gate acts asynchronously until exit.
// - input buffers are disabled during power-down and self refresh.
// - chip select low enables decoding; high masks every command.
// - with chip select high, running bursts and byte masking continue.
// - command decoded from chip select and the three strobes together.
// - masked write lanes are discarded, stored data unchanged.
// - masked read lanes go high impedance two clocks after sampling.
// - x16: low mask bits 7-0, high mask 15-8; narrower: high mask only.
// - two-bit bank select picks the bank for activate, read, write, precharge.
// - activate latches the full twelve-bit address as the row.
// - column from address: x4 bits 9-0 plus 11, x8 9-0, x16 8-0.
// - precharge flag bit on read or write selects auto precharge.
// - precharge flag high precharges all banks, low only the selected one.
// - mode load command takes its op-code from the address inputs.
// - data bus is sixteen, eight or four bits by variant.
// - burst lengths 1, 2, 4, 8 or full page, with burst terminate.
package sdram_pins_pkg;
  localparam int ADDR_W      = 12;
  localparam int BANK_W      = 2;
  localparam int BANKS       = 4;
  localparam int AP_BIT      = 10;
  localparam int X4_COL_HI   = 11;
  localparam int X8_COL_TOP  = 9;
  localparam int X16_COL_TOP = 8;
  localparam int BL_LSB      = 0;
  localparam int BL_W        = 3;
  localparam logic [BL_W-1:0] BL_FULL = 3'h7;
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_BST  = 3'h6;
  localparam logic [2:0] CMD_NOP  = 3'h7;
  localparam int BUF_DEPTH   = 2;
  typedef enum logic [2:0] {
    PM_RUN, PM_SUSPEND, PM_PRE_DOWN, PM_ACT_DOWN, PM_SELF_REF
  } power_mode_t;
endpackage

// ===== sdram_word_buffer.sv
// Purpose: small fifo between array reads and the data pins.
// Assumes: single clock, synchronous active-low reset.
// Notes: output data comes straight from the storage flops.
module sdram_word_buffer #(
  parameter int W     = 16,
  parameter int DEPTH = sdram_pins_pkg::BUF_DEPTH
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  import sdram_pins_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] data;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [PW:0]             count;
  } buf_t;
  buf_t buf_reg;
  buf_t buf_next;
  logic push;
  logic pop;

  assign in_ready_out  = buf_reg.count != (PW+1)'(DEPTH);
  assign out_valid_out = buf_reg.count != '0;
  assign out_data_out  = buf_reg.data[buf_reg.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_comb begin
    buf_next = buf_reg;
    if (push) begin
      buf_next.data[buf_reg.wr] = in_data_in;
      buf_next.wr = (buf_reg.wr == PW'(DEPTH-1)) ? '0 : buf_reg.wr + PW'(1);
    end
    if (pop) begin
      buf_next.rd = (buf_reg.rd == PW'(DEPTH-1)) ? '0 : buf_reg.rd + PW'(1);
    end
    buf_next.count = buf_reg.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      buf_reg <= '0;
    end else begin
      buf_reg <= buf_next;
    end
  end

  a_buf_bounded: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    buf_reg.count <= (PW+1)'(DEPTH)) else $error("buffer count overran");
  a_buf_holds: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (out_valid_out && !out_ready_in) |=> out_valid_out && $stable(out_data_out))
    else $error("stalled word changed");
endmodule

// ===== sdram_host_model.sv
// Purpose: host controller model driving the sdram pin command bus.
// Assumes: pins change on the falling clock edge and are sampled on the rising one.
// Notes: released address and data lines show the inverse of the last value.
module sdram_host_model #(
  parameter int DQ_W = 16
) (
  input  wire logic                              clk_in,
  output logic                                   clock_gate_out,
  output logic                                   chip_select_n_out,
  output logic                                   row_strobe_n_out,
  output logic                                   column_strobe_n_out,
  output logic                                   write_strobe_n_out,
  output logic [sdram_pins_pkg::BANK_W-1:0]      bank_select_out,
  output logic [sdram_pins_pkg::ADDR_W-1:0]      address_out,
  output logic                                   low_byte_mask_out,
  output logic                                   high_byte_mask_out,
  output logic [DQ_W-1:0]                        dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_pins_pkg::*;

  // gate high from time zero, so the part never starts asleep
  initial begin
    clock_gate_out = 1'b1;
    {chip_select_n_out, row_strobe_n_out, column_strobe_n_out, write_strobe_n_out} = 4'hf;
    bank_select_out = '0;
    address_out = '0;
    {low_byte_mask_out, high_byte_mask_out} = 2'h0;
    dq_out = '0;
  end

  // one cycle of pins, held through the sampling edge
  task automatic drive(input logic cs_n, input logic [2:0] code,
                       input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] addr,
                       input logic [DQ_W-1:0] d, input logic hm, input logic lm);
    chip_select_n_out = cs_n;
    {row_strobe_n_out, column_strobe_n_out, write_strobe_n_out} = code;
    bank_select_out = bank;
    address_out = addr;
    dq_out = d;
    high_byte_mask_out = hm;
    low_byte_mask_out = lm;
    @(negedge clk_in);
  endtask

  task automatic idle(input int n);
    chip_select_n_out = 1'b1;
    {row_strobe_n_out, column_strobe_n_out, write_strobe_n_out} = CMD_NOP;
    address_out = ~address_out;
    dq_out = ~dq_out;
    {low_byte_mask_out, high_byte_mask_out} = 2'h0;
    repeat (n) @(negedge clk_in);
  endtask

  task automatic set_gate(input logic g);
    clock_gate_out = g;
  endtask
endmodule

// ===== testbench.sv
// Purpose: self-checking bench for the sdram pin command interface, x16 build.
// Assumes: host model drives every pin on the falling edge.
// Notes: a read sampled at one edge shows its first word after the next edge.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_pins_pkg::*;
  logic clk, reset_n, gate, cs_n, ras_n, cas_n, we_n, lm, hm, ibuf, busy;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [15:0] dq_w, dq_r, oe, held;
  power_mode_t pmode;
  logic [BANKS-1:0] open_b;
  int bad_count, comparisons, cnt, i;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  sdram_host_model #(.DQ_W(16)) host (.clk_in(clk), .clock_gate_out(gate),
    .chip_select_n_out(cs_n), .row_strobe_n_out(ras_n), .column_strobe_n_out(cas_n),
    .write_strobe_n_out(we_n), .bank_select_out(bank), .address_out(addr),
    .low_byte_mask_out(lm), .high_byte_mask_out(hm), .dq_out(dq_w));
  sdram_pin_command_interface #(.DQ_W(16), .ROW_KEEP(2), .COL_KEEP(4)) dut (
    .clk_in(clk), .reset_n_in(reset_n), .clock_gate_in(gate), .chip_select_n_in(cs_n),
    .row_strobe_n_in(ras_n), .column_strobe_n_in(cas_n), .write_strobe_n_in(we_n),
    .bank_select_in(bank), .address_in(addr), .low_byte_mask_in(lm),
    .high_byte_mask_in(hm), .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(oe),
    .power_mode_out(pmode), .bank_open_out(open_b), .input_buffers_on_out(ibuf),
    .burst_active_out(busy));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wait_idle();
    for (i = 0; i < 40 && busy !== 1'b0; i++) host.idle(1);
    if (i == 40) begin
      bad_count++;
      $display("MISMATCH burst hang at %0t: got %h expected %h", $time, busy, 1'b0);
      summarize();
    end
  endtask

  // count beats with any lane driven over n cycles
  task automatic count_beats(input int n);
    repeat (n) begin
      if (oe !== 16'h0) cnt++;
      host.idle(1);
    end
  endtask

  task automatic t_reset();
    check({13'h0, pmode}, {13'h0, PM_RUN}, "mode");
    check({12'h0, open_b}, 16'h0, "banks");
    check(oe, 16'h0, "oe");
    check({15'h0, ibuf}, 16'h1, "buffers");
    $display("test reset done");
  endtask

  task automatic t_select();
    host.drive(1'b1, CMD_ACT, 2'h2, 12'h001, 16'h0, 1'b0, 1'b0);
    host.idle(1);
    check({12'h0, open_b}, 16'h0, "masked act");
    host.drive(1'b0, CMD_ACT, 2'h1, 12'hfff, 16'h0, 1'b0, 1'b0);
    host.idle(1);
    check({12'h0, open_b}, 16'h2, "act bank1");
    host.drive(1'b1, CMD_RD, 2'h1, 12'h000, 16'h0, 1'b0, 1'b0);
    host.idle(3);
    check(oe, 16'h0, "masked read");
    $display("test select done");
  endtask

  task automatic t_write_read();
    host.drive(1'b0, CMD_MODE, 2'h0, 12'h001, 16'h0, 1'b0, 1'b0);
    host.drive(1'b0, CMD_WR, 2'h1, 12'h002, 16'h1111, 1'b0, 1'b0);
    host.drive(1'b0, CMD_NOP, 2'h0, 12'h0, 16'h2222, 1'b0, 1'b0);
    host.drive(1'b0, CMD_WR, 2'h1, 12'h002, 16'h3333, 1'b1, 1'b0);
    host.drive(1'b1, CMD_NOP, 2'h0, 12'h0, 16'h4444, 1'b0, 1'b1);
    host.idle(1);
    // low mask taken with the read releases the low lane of the second word
    host.drive(1'b0, CMD_RD, 2'h1, 12'h002, 16'h0, 1'b0, 1'b1);
    host.drive(1'b1, CMD_NOP, 2'h0, 12'h0, 16'h0, 1'b0, 1'b0);
    check(dq_r, 16'h1133, "word0");
    check(oe, 16'hffff, "oe0");
    host.idle(1);
    check(oe, 16'hff00, "oe1");
    check({8'h0, dq_r[15:8]}, 16'h0044, "word1");
    wait_idle();
    $display("test write read done");
  endtask

  task automatic t_precharge();
    host.drive(1'b0, CMD_ACT, 2'h0, 12'h000, 16'h0, 1'b0, 1'b0);
    host.drive(1'b0, CMD_ACT, 2'h2, 12'h000, 16'h0, 1'b0, 1'b0);
    host.drive(1'b0, CMD_PRE, 2'h1, 12'h000, 16'h0, 1'b0, 1'b0);
    host.idle(1);
    check({12'h0, open_b}, 16'h5, "pre one");
    host.drive(1'b0, CMD_PRE, 2'h1, 12'h400, 16'h0, 1'b0, 1'b0);
    host.idle(1);
    check({12'h0, open_b}, 16'h0, "pre all");
    $display("test precharge done");
  endtask

  task automatic t_power();
    host.set_gate(1'b0);
    host.idle(2);
    check({13'h0, pmode}, {13'h0, PM_PRE_DOWN}, "pre down");
    check({15'h0, ibuf}, 16'h0, "buffers off");
    host.drive(1'b0, CMD_ACT, 2'h3, 12'h000, 16'h0, 1'b0, 1'b0);
    host.set_gate(1'b1);
    host.idle(1);
    check({13'h0, pmode}, {13'h0, PM_RUN}, "wake");
    check({12'h0, open_b}, 16'h0, "asleep act");
    host.drive(1'b0, CMD_ACT, 2'h3, 12'h000, 16'h0, 1'b0, 1'b0);
    host.set_gate(1'b0);
    host.idle(2);
    check({13'h0, pmode}, {13'h0, PM_ACT_DOWN}, "act down");
    host.set_gate(1'b1);
    host.idle(1);
    host.drive(1'b0, CMD_PRE, 2'h0, 12'h400, 16'h0, 1'b0, 1'b0);
    host.set_gate(1'b0);
    host.drive(1'b0, CMD_REF, 2'h0, 12'h000, 16'h0, 1'b0, 1'b0);
    host.idle(1);
    check({13'h0, pmode}, {13'h0, PM_SELF_REF}, "self refresh");
    host.set_gate(1'b1);
    host.idle(2);
    check({13'h0, pmode}, {13'h0, PM_RUN}, "run");
    $display("test power done");
  endtask

  task automatic t_bursts();
    host.drive(1'b0, CMD_ACT, 2'h0, 12'h000, 16'h0, 1'b0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      host.drive(1'b0, CMD_MODE, 2'h0, 12'(c), 16'h0, 1'b0, 1'b0);
      host.drive(1'b0, CMD_RD, 2'h0, 12'h000, 16'h0, 1'b0, 1'b0);
      cnt = 0;
      count_beats(14);
      check(16'(cnt), 16'(1 << c), "beats");
    end
    host.drive(1'b0, CMD_MODE, 2'h0, 12'h007, 16'h0, 1'b0, 1'b0);
    host.drive(1'b0, CMD_RD, 2'h0, 12'h000, 16'h0, 1'b0, 1'b0);
    cnt = 0;
    count_beats(14);
    check({15'h0, busy}, 16'h1, "full page runs");
    host.drive(1'b0, CMD_BST, 2'h0, 12'h000, 16'h0, 1'b0, 1'b0);
    count_beats(6);
    check({15'h0, busy}, 16'h0, "terminated");
    check(oe, 16'h0, "oe after stop");
    $display("test bursts done");
  endtask

  task automatic t_suspend();
    host.drive(1'b0, CMD_MODE, 2'h0, 12'h003, 16'h0, 1'b0, 1'b0);
    // eight write beats of column-coded data; the last one fully masked
    for (int k = 0; k < 8; k++) begin
      host.drive(k != 0, (k == 0) ? CMD_WR : CMD_NOP, 2'h0, 12'h000, {4{4'(k)}},
                 k == 7, k == 7);
    end
    host.drive(1'b0, CMD_RD, 2'h0, 12'h400, 16'h0, 1'b0, 1'b0);
    host.idle(2);
    host.set_gate(1'b0);
    host.idle(2);
    check({13'h0, pmode}, {13'h0, PM_SUSPEND}, "suspend");
    check(dq_r, 16'h2222, "suspended data");
    held = dq_r;
    host.idle(2);
    check(dq_r, held, "held word");
    check({15'h0, busy}, 16'h1, "frozen burst");
    host.set_gate(1'b1);
    wait_idle();
    host.idle(2);
    check({12'h0, open_b}, 16'h0, "auto precharge");
    $display("test suspend done");
  endtask

  initial begin
    bad_count = 0;
    comparisons = 0;
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_select();
    t_write_read();
    t_precharge();
    t_power();
    t_bursts();
    t_suspend();
    summarize();
  end
endmodule
